/* verilog/ucpm_pkg.sv */
package ucpm_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0]  UCPM_REG_CTRL    = 8'h00;
  localparam logic [7:0]  UCPM_REG_GPIO    = 8'h04;
  localparam logic [7:0]  UCPM_REG_STAT    = 8'h08;
  localparam int          UCPM_SEL_W       = 5;
  localparam int          UCPM_CANCEL_BIT  = 20;
  localparam int          UCPM_APPLY_BIT   = 31;
  localparam int          UCPM_GPIO_OE_LSB = 4;
  localparam logic [31:0] UCPM_CTRL_RST    = 32'h0000_0000;
  localparam logic [3:0]  UCPM_GPIO_RST    = 4'h0;
  localparam logic [1:0]  UCPM_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  UCPM_RESP_SLVERR = 2'h2;

  // ==========================================================
  // Timing
  localparam int UCPM_CLK_MHZ      = 40;
  localparam int UCPM_LED_PULSE_NS = 50000;
  localparam int UCPM_LED_CNT_W    = 11;
  localparam int UCPM_LED_PULSE_I  = (UCPM_LED_PULSE_NS * UCPM_CLK_MHZ + 999) / 1000;
  localparam logic [UCPM_LED_CNT_W-1:0] UCPM_LED_PULSE_CYC = UCPM_LED_PULSE_I[UCPM_LED_CNT_W-1:0];

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    UCPM_FN_TRISTATE, UCPM_FN_XCVR_EN, UCPM_FN_DRIVE_1, UCPM_FN_DRIVE_0,
    UCPM_FN_PWR_EN, UCPM_FN_TX_LED, UCPM_FN_RX_LED, UCPM_FN_ANY_LED,
    UCPM_FN_SLEEP, UCPM_FN_CLK_FAST, UCPM_FN_CLK_MID, UCPM_FN_CLK_SLOW,
    UCPM_FN_GPIO, UCPM_FN_CHG_HI, UCPM_FN_CHG_LO, UCPM_FN_BB_WR,
    UCPM_FN_BB_RD, UCPM_FN_BUS_SENSE, UCPM_FN_TIMESTAMP, UCPM_FN_KEEP_AWAKE
  } ucpm_fn_t;

  typedef enum logic [1:0] {UCPM_BB_OFF, UCPM_BB_ASYNC, UCPM_BB_SYNC} ucpm_bb_mode_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } ucpm_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ucpm_axi_rsp_t;

  typedef struct packed {
    logic configured;
    logic suspend;
    logic charger;
    logic sof;
    logic tx_act;
    logic rx_act;
  } ucpm_usb_t;

  typedef struct packed {
    ucpm_bb_mode_t mode;
    logic          write_strobe_n;
    logic          read_strobe_n;
  } ucpm_bb_t;

  typedef struct packed {
    logic fast;
    logic mid;
    logic slow;
  } ucpm_clk_t;

  typedef struct packed {
    logic xcvr;
    logic pwr_low;
    logic tx_led;
    logic rx_led;
    logic sleep_hi;
    logic chg;
    logic bb_wr_n;
    logic bb_rd_n;
    logic sof_tgl;
    ucpm_clk_t clk;
  } ucpm_ctx_t;

  typedef struct packed {
    ucpm_fn_t [3:0]            sel;
    logic                      cancel_sleep;
    logic                      applied;
    logic [3:0]                gpio_out;
    logic [3:0]                gpio_oe;
    logic                      sof_tgl;
    logic [UCPM_LED_CNT_W-1:0] tx_cnt;
    logic [UCPM_LED_CNT_W-1:0] rx_cnt;
    logic                      cts_n;
    logic                      rts_n;
    logic                      bus_power;
    logic                      stay_awake;
    logic                      aw_got;
    logic [7:0]                awaddr;
    logic                      w_got;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
  } ucpm_state_t;

endpackage : ucpm_pkg

/* verilog/ucpm_pin_mux.sv */
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - Each of four pins takes its own function from the stored configuration.
// - Transceiver-enable function drives high while the UART transmits.
// - Power-enable goes low once configured, returns high in suspend.
// - Power-enable only pulls low, releasing the line for high.
// - Transmit LED pulses low open-drain while USB data is sent.
// - Receive LED pulses low open-drain while USB data is received.
// - Combined LED pulses low open-drain on send or receive.
// - Sleep indicator driven low during suspend, high otherwise.
// - With cancel-sleep set, sleep indicator stays high on a charger port.
// - Clock functions drive one of three internal clocks onto a pin.
// - Clock outputs stop for the whole of USB suspend.
// - Up to four pins act as individual bit bang inputs or outputs.
// - Active-high charger detect is high while on a dedicated charger.
// - Active-low charger detect pulls low open-drain while charger found.
// - Write-strobe function outputs the bit bang write strobe, both modes.
// - Read-strobe function outputs the bit bang read strobe, both modes.
// - Bus-power sense function is an input reporting bus power.
// - Timestamp function toggles once per start-of-frame.
// - Stay-awake pin held low by board logic blocks suspend.
// - Reset low holds the block in reset; high resumes.
// - Device drives request-to-send and samples clear-to-send.
// - Asynchronous and synchronous bit bang modes beside normal UART.
module ucpm_pin_mux (
  // Clock and reset
  input  logic                   aclk,
  input  logic                   aresetn,
  // Register bus
  input  ucpm_pkg::ucpm_axi_req_t axi_req,
  output ucpm_pkg::ucpm_axi_rsp_t axi_rsp,
  // Engines
  input  ucpm_pkg::ucpm_usb_t     usb,
  input  ucpm_pkg::ucpm_bb_t      bb,
  input  ucpm_pkg::ucpm_clk_t     clk_src,
  input  logic                   uart_tx_busy,
  input  logic                   rts_req,
  output logic                   cts_ok,
  output logic                   bus_power_sense,
  output logic                   suspend_inhibit,
  // UART handshake pins
  output logic                   rts_n,
  input  logic                   cts_n,
  // Configurable pins
  input  logic [3:0]             cfg_pin_in,
  output logic [3:0]             cfg_pin_out,
  output logic [3:0]             cfg_pin_oe
);
  import ucpm_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [1:0] pin_drive(ucpm_fn_t fn, logic g_out, logic g_oe,
                                           ucpm_ctx_t c);
    logic [1:0] r;
    r = 2'h0;
    case (fn)
      UCPM_FN_XCVR_EN:  r = {1'b1, c.xcvr};
      UCPM_FN_DRIVE_1:  r = 2'h3;
      UCPM_FN_DRIVE_0:  r = 2'h2;
      UCPM_FN_PWR_EN:   r = {c.pwr_low, 1'b0};
      UCPM_FN_TX_LED:   r = {c.tx_led, 1'b0};
      UCPM_FN_RX_LED:   r = {c.rx_led, 1'b0};
      UCPM_FN_ANY_LED:  r = {c.tx_led | c.rx_led, 1'b0};
      UCPM_FN_SLEEP:    r = {1'b1, c.sleep_hi};
      UCPM_FN_CLK_FAST: r = {1'b1, c.clk.fast};
      UCPM_FN_CLK_MID:  r = {1'b1, c.clk.mid};
      UCPM_FN_CLK_SLOW: r = {1'b1, c.clk.slow};
      UCPM_FN_GPIO:     r = {g_oe, g_out};
      UCPM_FN_CHG_HI:   r = {1'b1, c.chg};
      UCPM_FN_CHG_LO:   r = {c.chg, 1'b0};
      UCPM_FN_BB_WR:    r = {1'b1, c.bb_wr_n};
      UCPM_FN_BB_RD:    r = {1'b1, c.bb_rd_n};
      UCPM_FN_TIMESTAMP: r = {1'b1, c.sof_tgl};
      default:          r = 2'h0;
    endcase
    return r;
  endfunction : pin_drive

  function automatic logic [31:0] merge_strb(logic [31:0] old_v, logic [31:0] new_v,
                                             logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_strb

  // ==========================================================
  // State
  ucpm_state_t s_q;
  ucpm_state_t s_d;
  ucpm_ctx_t   ctx;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        wr_go;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [31:0] ctrl_rd;
  logic [31:0] ctrl_new;
  logic [31:0] gpio_new;
  logic [3:0]  keep_mask;
  logic [3:0]  sense_mask;

  // ==========================================================
  // Register bus handshakes
  assign axi_rsp.awready = !s_q.aw_got && !s_q.bvalid;
  assign axi_rsp.wready  = !s_q.w_got && !s_q.bvalid;
  assign axi_rsp.arready = !s_q.rvalid;
  assign axi_rsp.bvalid  = s_q.bvalid;
  assign axi_rsp.bresp   = s_q.bresp;
  assign axi_rsp.rvalid  = s_q.rvalid;
  assign axi_rsp.rdata   = s_q.rdata;
  assign axi_rsp.rresp   = s_q.rresp;

  assign aw_take = axi_req.awvalid && axi_rsp.awready;
  assign w_take  = axi_req.wvalid && axi_rsp.wready;
  assign ar_take = axi_req.arvalid && axi_rsp.arready;
  assign wr_go   = (s_q.aw_got || aw_take) && (s_q.w_got || w_take);
  assign wr_addr = s_q.aw_got ? s_q.awaddr : axi_req.awaddr;
  assign wr_data = s_q.w_got ? s_q.wdata : axi_req.wdata;
  assign wr_strb = s_q.w_got ? s_q.wstrb : axi_req.wstrb;

  always_comb begin
    ctrl_rd = UCPM_CTRL_RST;
    for (int i = 0; i < 4; i++) begin
      ctrl_rd[i*UCPM_SEL_W +: UCPM_SEL_W] = s_q.sel[i];
    end
    ctrl_rd[UCPM_CANCEL_BIT] = s_q.cancel_sleep;
    ctrl_rd[UCPM_APPLY_BIT]  = s_q.applied;
  end

  assign ctrl_new = merge_strb(ctrl_rd, wr_data, wr_strb);
  assign gpio_new = merge_strb({24'h00_0000, s_q.gpio_oe, s_q.gpio_out}, wr_data, wr_strb);

  // ==========================================================
  // Function context
  always_comb begin
    ctx          = '0;
    ctx.xcvr     = uart_tx_busy;
    ctx.pwr_low  = usb.configured && !usb.suspend;
    ctx.tx_led   = s_q.tx_cnt != '0;
    ctx.rx_led   = s_q.rx_cnt != '0;
    ctx.sleep_hi = !usb.suspend || (s_q.cancel_sleep && usb.charger);
    ctx.chg      = usb.charger;
    ctx.bb_wr_n  = (bb.mode == UCPM_BB_OFF) || bb.write_strobe_n;
    ctx.bb_rd_n  = (bb.mode == UCPM_BB_OFF) || bb.read_strobe_n;
    ctx.sof_tgl  = s_q.sof_tgl;
    ctx.clk.fast = clk_src.fast && !usb.suspend;
    ctx.clk.mid  = clk_src.mid && !usb.suspend;
    ctx.clk.slow = clk_src.slow && !usb.suspend;
  end

  // ==========================================================
  // Pin mux
  always_comb begin
    logic [1:0] d;
    d           = 2'h0;
    cfg_pin_out = 4'h0;
    cfg_pin_oe  = 4'h0;
    keep_mask   = 4'h0;
    sense_mask  = 4'h0;
    for (int i = 0; i < 4; i++) begin
      d              = pin_drive(s_q.sel[i], s_q.gpio_out[i], s_q.gpio_oe[i], ctx);
      cfg_pin_oe[i]  = d[1] && s_q.applied;
      cfg_pin_out[i] = d[0] && s_q.applied;
      keep_mask[i]   = s_q.applied && (s_q.sel[i] == UCPM_FN_KEEP_AWAKE);
      sense_mask[i]  = s_q.applied && (s_q.sel[i] == UCPM_FN_BUS_SENSE);
    end
  end

  assign rts_n           = s_q.rts_n;
  assign cts_ok          = !s_q.cts_n;
  assign bus_power_sense = s_q.bus_power;
  assign suspend_inhibit = s_q.stay_awake;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    // Activity stretch; a new event reloads the full width
    if (usb.tx_act) begin
      s_d.tx_cnt = UCPM_LED_PULSE_CYC;
    end else if (s_q.tx_cnt != '0) begin
      s_d.tx_cnt = s_q.tx_cnt - 1'b1;
    end
    if (usb.rx_act) begin
      s_d.rx_cnt = UCPM_LED_PULSE_CYC;
    end else if (s_q.rx_cnt != '0) begin
      s_d.rx_cnt = s_q.rx_cnt - 1'b1;
    end
    if (usb.sof) begin
      s_d.sof_tgl = !s_q.sof_tgl;
    end
    s_d.rts_n      = !rts_req;
    s_d.cts_n      = cts_n;
    s_d.bus_power  = |(sense_mask & cfg_pin_in);
    s_d.stay_awake = |(keep_mask & ~cfg_pin_in);
    // Write channel
    if (aw_take) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = axi_req.awaddr;
    end
    if (w_take) begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req.wdata;
      s_d.wstrb = axi_req.wstrb;
    end
    if (wr_go) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = UCPM_RESP_OKAY;
      case (wr_addr)
        UCPM_REG_CTRL: begin
          for (int i = 0; i < 4; i++) begin
            s_d.sel[i] = ucpm_fn_t'(ctrl_new[i*UCPM_SEL_W +: UCPM_SEL_W]);
          end
          s_d.cancel_sleep = ctrl_new[UCPM_CANCEL_BIT];
          s_d.applied      = ctrl_new[UCPM_APPLY_BIT];
        end
        UCPM_REG_GPIO: begin
          s_d.gpio_out = gpio_new[3:0];
          s_d.gpio_oe  = gpio_new[UCPM_GPIO_OE_LSB +: 4];
        end
        UCPM_REG_STAT: s_d.bresp = UCPM_RESP_OKAY;
        default:       s_d.bresp = UCPM_RESP_SLVERR;
      endcase
    end else if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end
    // Read channel
    if (ar_take) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = UCPM_RESP_OKAY;
      case (axi_req.araddr)
        UCPM_REG_CTRL: s_d.rdata = ctrl_rd;
        UCPM_REG_GPIO: s_d.rdata = {24'h00_0000, s_q.gpio_oe, s_q.gpio_out};
        UCPM_REG_STAT: s_d.rdata = {21'h00_0000, s_q.applied, s_q.stay_awake,
                                    s_q.bus_power, !s_q.cts_n, usb.charger,
                                    usb.configured, usb.suspend, cfg_pin_in};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = UCPM_RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q       <= '0;
      s_q.rts_n <= 1'b1;
      s_q.cts_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic od_bad;
  always_comb begin
    od_bad = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (cfg_pin_oe[i] && cfg_pin_out[i] &&
          (s_q.sel[i] inside {UCPM_FN_PWR_EN, UCPM_FN_TX_LED, UCPM_FN_RX_LED,
                              UCPM_FN_ANY_LED, UCPM_FN_CHG_LO})) begin
        od_bad = 1'b1;
      end
    end
  end

  a_pins_float_unapplied: assert property (!s_q.applied |-> cfg_pin_oe == 4'h0)
    else $error("pin driven before configuration applied");
  a_open_drain_low: assert property (!od_bad)
    else $error("open-drain function drove a pin high");
  a_tx_led_stretch: assert property (usb.tx_act |=> s_q.tx_cnt == UCPM_LED_PULSE_CYC)
    else $error("transmit activity did not reload the pulse");
  a_rx_led_stretch: assert property (usb.rx_act ##1 !usb.rx_act |=>
                                     s_q.rx_cnt == UCPM_LED_PULSE_CYC - 1'b1)
    else $error("receive pulse did not count down");
  a_sof_toggle: assert property (usb.sof |=> s_q.sof_tgl != $past(s_q.sof_tgl))
    else $error("timestamp did not toggle on frame start");
  a_clock_stops: assert property (s_q.applied && usb.suspend &&
                                  s_q.sel[0] inside {UCPM_FN_CLK_FAST, UCPM_FN_CLK_MID,
                                                     UCPM_FN_CLK_SLOW} |-> !cfg_pin_out[0])
    else $error("clock output running in suspend");
  a_sleep_low: assert property (s_q.applied && s_q.sel[0] == UCPM_FN_SLEEP && usb.suspend &&
                                !(s_q.cancel_sleep && usb.charger) |-> cfg_pin_oe[0] && !cfg_pin_out[0])
    else $error("sleep indicator not low in suspend");
  a_apply_write: assert property (wr_go && wr_addr == UCPM_REG_CTRL && wr_strb[3] |=>
                                  s_q.applied == $past(wr_data[UCPM_APPLY_BIT]))
    else $error("apply bit not taken from write");
  a_rts_follow: assert property (rts_req |=> !rts_n)
    else $error("request-to-send not driven");
  a_reset_clear: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> !s_q.applied)
    else $error("reset did not clear configuration");
  a_xcvr_follow: assert property (s_q.applied && s_q.sel[0] == UCPM_FN_XCVR_EN |->
                                  cfg_pin_oe[0] && cfg_pin_out[0] == uart_tx_busy)
    else $error("transceiver enable does not follow the transmitter");
  a_pwr_active: assert property (s_q.applied && s_q.sel[0] == UCPM_FN_PWR_EN && usb.configured &&
                                 !usb.suspend |-> cfg_pin_oe[0] && !cfg_pin_out[0])
    else $error("power enable not low once configured");
  a_pwr_release: assert property (s_q.applied && s_q.sel[0] == UCPM_FN_PWR_EN &&
                                  !(usb.configured && !usb.suspend) |-> !cfg_pin_oe[0])
    else $error("power enable not released for its high state");
  a_any_led: assert property (s_q.applied && s_q.sel[0] == UCPM_FN_ANY_LED && usb.rx_act ##1
                              s_q.applied && s_q.sel[0] == UCPM_FN_ANY_LED |->
                              cfg_pin_oe[0] && !cfg_pin_out[0])
    else $error("combined LED not pulled low after activity");
  a_charger_high: assert property (s_q.applied && s_q.sel[0] == UCPM_FN_CHG_HI && usb.charger |->
                                   cfg_pin_oe[0] && cfg_pin_out[0])
    else $error("charger detect not high on a charger");
  a_charger_low: assert property (s_q.applied && s_q.sel[0] == UCPM_FN_CHG_LO && usb.charger |->
                                  cfg_pin_oe[0] && !cfg_pin_out[0])
    else $error("charger detect not pulled low on a charger");
  a_sleep_cancel: assert property (s_q.applied && s_q.sel[0] == UCPM_FN_SLEEP && s_q.cancel_sleep &&
                                   usb.charger |-> cfg_pin_oe[0] && cfg_pin_out[0])
    else $error("sleep indicator not high on a charger port");
  a_strobe_idle: assert property (s_q.applied && s_q.sel[0] == UCPM_FN_BB_WR &&
                                  bb.mode == UCPM_BB_OFF |-> cfg_pin_oe[0] && cfg_pin_out[0])
    else $error("write strobe active outside bit bang mode");
  a_keep_awake: assert property (s_q.applied && s_q.sel[0] == UCPM_FN_KEEP_AWAKE &&
                                 !cfg_pin_in[0] |=> suspend_inhibit)
    else $error("held keep-awake pin did not block suspend");
  a_cts_sample: assert property (!cts_n |=> cts_ok)
    else $error("clear-to-send not sampled");

  c_apply: cover property (wr_go && wr_addr == UCPM_REG_CTRL ##1 s_q.applied);
  c_led_expire: cover property (s_q.tx_cnt == 1 && !usb.tx_act ##1 s_q.tx_cnt == 0);
  c_read_stat: cover property (ar_take && axi_req.araddr == UCPM_REG_STAT);
  c_keep_awake: cover property (suspend_inhibit);
  c_gpio_drive: cover property (s_q.applied && s_q.sel[0] == UCPM_FN_GPIO && cfg_pin_oe[0]);

endmodule : ucpm_pin_mux

/* verif/ucpm_board.sv */
`timescale 1ns/1ps
// ==========================================================
// Board side: pull-ups, input drivers, UART partner
module ucpm_board #(
  parameter int CTS_LAT = 2
) (
  // Clock
  input  logic       aclk,
  // Configurable pins
  input  logic [3:0] pin_out,
  input  logic [3:0] pin_oe,
  input  logic [3:0] hold_low,
  output logic [3:0] pin_level,
  // UART handshake
  input  logic       rts_n,
  output logic       cts_n
);
  logic [7:0] rts_hist = 8'hff;

  // Released lines rise through the board pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : !hold_low[i];
    end
  end

  // Grant clear-to-send some cycles after the request
  always_ff @(posedge aclk) begin
    rts_hist <= {rts_hist[6:0], rts_n};
  end
  assign cts_n = rts_hist[CTS_LAT-1];
endmodule : ucpm_board

/* verif/test_ucpm_pin_mux.sv */
`timescale 1ns/1ps
module test_ucpm_pin_mux;
  import ucpm_pkg::*;
  logic          aclk, aresetn, uart_tx_busy, rts_req, cts_ok, bus_power_sense, suspend_inhibit, rts_n, cts_n, t;
  logic [3:0]    cfg_pin_in, cfg_pin_out, cfg_pin_oe, hold_low;
  logic [31:0]   d;
  logic [1:0]    r, br;
  ucpm_axi_req_t req;
  ucpm_axi_rsp_t rsp;
  ucpm_usb_t     usb;
  ucpm_bb_t      bb;
  ucpm_clk_t     clk_src;
  int            n_errors, checks_done;

  ucpm_pin_mux u_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .usb(usb), .bb(bb),
    .clk_src(clk_src), .uart_tx_busy(uart_tx_busy), .rts_req(rts_req), .cts_ok(cts_ok),
    .bus_power_sense(bus_power_sense), .suspend_inhibit(suspend_inhibit), .rts_n(rts_n), .cts_n(cts_n),
    .cfg_pin_in(cfg_pin_in), .cfg_pin_out(cfg_pin_out), .cfg_pin_oe(cfg_pin_oe));
  ucpm_board u_board (.aclk(aclk), .pin_out(cfg_pin_out), .pin_oe(cfg_pin_oe), .hold_low(hold_low),
    .pin_level(cfg_pin_in), .rts_n(rts_n), .cts_n(cts_n));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ==========================================================
  // Bus and check tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      n_errors++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1; req.wdata <= v; req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && rsp.awready === 1'b1) begin aw = 1'b0; req.awvalid <= 1'b0; end
      if (w && rsp.wready === 1'b1) begin w = 1'b0; req.wvalid <= 1'b0; end
    end while (rsp.bvalid !== 1'b1);
    br = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    v = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd

  // Pin 0 takes the code, pin 3 drives low throughout
  task setfn(input logic [4:0] f, input logic c = 1'b0);
    wr(UCPM_REG_CTRL, {1'b1, 10'h0, c, 5'd3, 10'h0, f});
  endtask : setfn

  task look(input logic oe, input logic lv);
    #1;
    chk(cfg_pin_oe[0], oe);
    chk(cfg_pin_in[0], lv);
  endtask : look

  task tend(input string s);
    $display("test %s done", s);
  endtask : tend

  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    end_of_test;
  end

  // ==========================================================
  // Tests
  initial begin
    req = '0; usb = '0; bb = '0; clk_src = '0; uart_tx_busy = 0; rts_req = 0; hold_low = '0; aresetn = 0;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge aclk);
    chk(cfg_pin_oe, 4'h0);
    chk(rts_n, 1'b1);
    aresetn <= 1'b1;
    rd(UCPM_REG_CTRL, d, r);
    chk(d, UCPM_CTRL_RST);
    rd(8'h0c, d, r);
    chk(r, UCPM_RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h0c, 32'h0);
    chk(br, UCPM_RESP_SLVERR);
    wr(UCPM_REG_STAT, 32'hffff_ffff);
    chk(br, UCPM_RESP_OKAY);
    wr(UCPM_REG_CTRL, 32'h0001_8002);
    look(1'b0, 1'b1);
    setfn(UCPM_FN_DRIVE_1);
    look(1'b1, 1'b1);
    chk(cfg_pin_in[3], 1'b0);
    tend("reset_apply");
    setfn(UCPM_FN_XCVR_EN);
    @(posedge aclk); uart_tx_busy <= 1'b1; look(1'b1, 1'b1);
    @(posedge aclk); uart_tx_busy <= 1'b0; look(1'b1, 1'b0);
    setfn(UCPM_FN_PWR_EN);
    look(1'b0, 1'b1);
    @(posedge aclk); usb.configured <= 1'b1; look(1'b1, 1'b0);
    @(posedge aclk); usb.suspend <= 1'b1; look(1'b0, 1'b1);
    setfn(UCPM_FN_SLEEP);
    look(1'b1, 1'b0);
    @(posedge aclk); usb.suspend <= 1'b0; look(1'b1, 1'b1);
    @(posedge aclk); usb.suspend <= 1'b1; usb.charger <= 1'b1; look(1'b1, 1'b0);
    setfn(UCPM_FN_SLEEP, 1'b1);
    look(1'b1, 1'b1);
    tend("power_sleep");
    for (int k = 0; k < 3; k++) begin
      setfn(5'(UCPM_FN_CLK_FAST + k));
      @(posedge aclk); usb.suspend <= 1'b0; clk_src <= 3'b100 >> k; look(1'b1, 1'b1);
      @(posedge aclk); clk_src <= ~(3'b100 >> k); look(1'b1, 1'b0);
      @(posedge aclk); clk_src <= 3'b111; usb.suspend <= 1'b1; look(1'b1, 1'b0);
    end
    @(posedge aclk); usb.suspend <= 1'b0; usb.charger <= 1'b0;
    tend("clocks");
    setfn(UCPM_FN_GPIO);
    wr(UCPM_REG_GPIO, 32'h11);
    look(1'b1, 1'b1);
    wr(UCPM_REG_GPIO, 32'h10);
    look(1'b1, 1'b0);
    rd(UCPM_REG_STAT, d, r);
    chk(d[3:0], 4'h6);
    wr(UCPM_REG_GPIO, 32'h00);
    look(1'b0, 1'b1);
    setfn(UCPM_FN_CHG_HI);
    @(posedge aclk); usb.charger <= 1'b1; look(1'b1, 1'b1);
    @(posedge aclk); usb.charger <= 1'b0; look(1'b1, 1'b0);
    setfn(UCPM_FN_CHG_LO);
    look(1'b0, 1'b1);
    @(posedge aclk); usb.charger <= 1'b1; look(1'b1, 1'b0);
    tend("gpio_charger");
    for (int k = 0; k < 2; k++) begin
      setfn(5'(UCPM_FN_BB_WR + k));
      for (int m = 0; m < 3; m++) begin
        @(posedge aclk); bb.mode <= ucpm_bb_mode_t'(m); bb.write_strobe_n <= 1'b0; bb.read_strobe_n <= 1'b0;
        look(1'b1, m == 0);
      end
      @(posedge aclk); bb.write_strobe_n <= 1'b1; bb.read_strobe_n <= 1'b1; look(1'b1, 1'b1);
    end
    tend("strobes");
    setfn(UCPM_FN_BUS_SENSE);
    @(posedge aclk); hold_low <= 4'h1; repeat (2) @(posedge aclk); look(1'b0, 1'b0);
    chk(bus_power_sense, 1'b0);
    @(posedge aclk); hold_low <= 4'h0; repeat (2) @(posedge aclk); #1;
    chk(bus_power_sense, 1'b1);
    setfn(UCPM_FN_KEEP_AWAKE);
    @(posedge aclk); hold_low <= 4'h1; repeat (2) @(posedge aclk); #1;
    chk(suspend_inhibit, 1'b1);
    @(posedge aclk); hold_low <= 4'h0; repeat (2) @(posedge aclk); #1;
    chk(suspend_inhibit, 1'b0);
    setfn(UCPM_FN_TIMESTAMP);
    #1 t = cfg_pin_in[0];
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk); usb.sof <= 1'b1;
      @(posedge aclk); usb.sof <= 1'b0;
      @(posedge aclk); t = !t; look(1'b1, t);
    end
    @(posedge aclk); rts_req <= 1'b1; repeat (5) @(posedge aclk); #1;
    chk(rts_n, 1'b0);
    chk(cts_ok, 1'b1);
    tend("inputs_sof_handshake");
    for (int k = 0; k < 3; k++) begin
      for (int s = 0; s < 2; s++) begin
        setfn(5'(UCPM_FN_TX_LED + k));
        look(1'b0, 1'b1);
        @(posedge aclk); usb.tx_act <= (s == 0); usb.rx_act <= (s == 1);
        @(posedge aclk); usb.tx_act <= 1'b0; usb.rx_act <= 1'b0;
        t = (k == 2) || (k == s);
        look(t, !t);
        repeat (1000) @(posedge aclk); look(t, !t);
        repeat (UCPM_LED_PULSE_CYC) @(posedge aclk); look(1'b0, 1'b1);
      end
    end
    tend("leds");
    end_of_test;
  end
endmodule : test_ucpm_pin_mux
